/* File: verilog/i2cbl_pkg.sv */
// Constants and types for the serial control and boot-load block.
// Behaviour
// RL1: Every address and data unit is one byte, shifted most significant bit first.
// RL2: The receiver of each byte pulls the data line low in its acknowledge slot.
// RL3: Start is data falling while clock is high; stop is data rising while high.
// RL4: Apart from start and stop, the data line changes only while the clock is low.
// RL5: After start the master sends seven address bits, direction bit, then awaits ack.
// RL6: The slave accepts any number of bytes between start and stop.
// RL7: A host read needs a subaddress-only write first, then the read transaction.
// RL8: In a write, the first data byte is the subaddress; later bytes are data.
// RL9: A new write after a subaddress-only write takes its first byte as new subaddress.
// RL10: The loader downloads any memory or part of one without wait states.
// RL11: Download switches from address write to read by repeated start, no stop.
// RL12: Download opens with start, memory address with write direction, subaddress bytes.
// RL13: The loader acknowledges every byte it reads from the memory; the code leaves the byte that ends the read unacknowledged.
// RL14: The image starts at memory location zero; blocks follow with no gaps.
// RL15: Loading goes on until bad header, end of memory, checksum error or end header.
// RL16: A bad header or read error is tried three times in total before error.
// RL17: A checksum mismatch re-reads the block twice more before declaring error.
// RL18: Once the controller program is loaded it is not reloaded until reset.
// RL19: On final error the load stops, defaults apply, master activity ends.
// RL20: Stored start word, stored end word and computed sum must all match.
// RL21: The checksum is a byte sum, checksum fields excluded, kept to 16 bits.
// RL22: Controller program and data blocks carry a multiple of four bytes.
// RL23: A header with zero length ends the download and hands over to slave mode.
// RL24: A header is accepted only when its two identity bytes equal 001F.
// RL25: The target code selects program, external data, DSP program, coefficient, data.
// RL26: The master clocks memory transfers at 375 kbps.
// RL27: A finished or abandoned download ends with a stop before slave operation.
package i2cbl_pkg;
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int MST_RATE_KBPS = 375;
  localparam int QTR_CYC = (CLK_FREQ_KHZ + 4 * MST_RATE_KBPS - 1) / (4 * MST_RATE_KBPS);
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
  localparam logic [6:0] EE_DEV = 7'h50;
  localparam logic [15:0] HDR_ID = 16'h001F;
  localparam logic [15:0] HDR_LEN = 16'h000C;
  localparam logic [15:0] CKS_LEN = 16'h0002;
  localparam logic [15:0] POS_CKS_HI = 16'h0000;
  localparam logic [15:0] POS_CKS_LO = 16'h0001;
  localparam logic [15:0] POS_ID_HI = 16'h0002;
  localparam logic [15:0] POS_ID_LO = 16'h0003;
  localparam logic [15:0] POS_SEL = 16'h0004;
  localparam logic [15:0] POS_ADR_HI = 16'h0006;
  localparam logic [15:0] POS_ADR_LO = 16'h0007;
  localparam logic [15:0] POS_TOT_HI = 16'h0008;
  localparam logic [15:0] POS_TOT_LO = 16'h0009;
  localparam logic [15:0] POS_HDR_LAST = 16'h000B;
  localparam logic [7:0] MEM_MCU_PROG = 8'h00;
  localparam logic [7:0] MEM_MCU_XDATA = 8'h01;
  localparam logic [7:0] MEM_DSP_PROG = 8'h02;
  localparam logic [7:0] MEM_DSP_COEF = 8'h03;
  localparam logic [7:0] MEM_DSP_DATA = 8'h04;
  localparam logic [1:0] TRIES_LAST = 2'h2;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [2:0] STP_AW = 3'h0;
  localparam logic [2:0] STP_SH = 3'h1;
  localparam logic [2:0] STP_SL = 3'h2;
  localparam logic [2:0] STP_AR = 3'h3;
  localparam logic [2:0] STP_RD = 3'h4;

  typedef enum logic [3:0] {
    S_START = 4'h1,
    S_BYTE = 4'h2,
    S_STOP = 4'h4,
    S_SLAVE = 4'h8
  } i2cbl_mst_st_t;

  typedef enum logic [4:0] {
    SL_IDLE = 5'h01,
    SL_RX = 5'h02,
    SL_ACK = 5'h04,
    SL_TX = 5'h08,
    SL_MACK = 5'h10
  } i2cbl_slv_st_t;

  typedef struct packed {
    logic [7:0] sel;
    logic [15:0] addr;
    logic [7:0] data;
  } i2cbl_mem_wr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } i2cbl_slv_wr_t;
endpackage

/* File: verilog/i2cbl_top.sv */
// Boot loader master, subaddress slave and the load-data FIFO.
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Load-data FIFO with a registered output stage.
// ****************************************************************
module i2cbl_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output var logic out_valid,
  output var logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = cnt_r != (AW + 1)'(D);
  assign push = in_valid && in_ready;
  assign pop = (cnt_r != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop)
      begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data <= mem_r[rp_r];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ****************************************************************
// Top: boot download as master, then subaddress slave.
// ****************************************************************
module i2cbl_top #(
  parameter int EE_BYTES = 65536,
  parameter logic [6:0] SLV_ADDR = 7'h34
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Serial bus pins.
  input wire logic scl_i,
  output var logic scl_o,
  output var logic scl_oe_n,
  input wire logic sda_i,
  output var logic sda_o,
  output var logic sda_oe_n,
  // Memory load stream.
  output logic mem_wr_valid,
  output i2cbl_pkg::i2cbl_mem_wr_t mem_wr_data,
  input wire logic mem_wr_ready,
  // Slave register access.
  output var logic slv_wr,
  output var i2cbl_pkg::i2cbl_slv_wr_t slv_wdata,
  output var logic [7:0] slv_sub,
  input wire logic [7:0] slv_rdata,
  // Boot status.
  output var logic boot_done,
  output var logic boot_err,
  output var logic use_default,
  output var logic mem_rd_err,
  output var logic mcu_locked
);
  import i2cbl_pkg::*;

  i2cbl_mst_st_t st_r;
  i2cbl_slv_st_t sl_st_r;
  logic [6:0] cnt_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [2:0] step_r;
  logic [7:0] sh_r;
  logic m_scl_low_r;
  logic m_sda_low_r;
  logic fin_r;
  logic fail_r;
  logic [1:0] tries_r;
  logic [15:0] pos_r;
  logic [15:0] base_r;
  logic [15:0] cks_hdr_r;
  logic [15:0] id_r;
  logic [7:0] sel_r;
  logic [15:0] start_r;
  logic [15:0] tot_r;
  logic [7:0] cke_hi_r;
  logic [15:0] sum_r;
  logic scl_q_r;
  logic sda_q_r;
  logic s_sda_low_r;
  logic [7:0] sl_sh_r;
  logic [3:0] sl_bit_r;
  logic sl_first_r;
  logic sl_rd_r;
  logic sl_sub_pend_r;
  logic tick;
  logic rd;
  logic bdone;
  logic [16:0] ee_pos;
  logic hdr_end;
  logic id_bad;
  logic term;
  logic is_data;
  logic blk_end;
  logic cks_ok;
  logic eom;
  logic fault;
  logic rd_stop;
  logic mem_push;
  logic fifo_in_ready;
  logic s_start;
  logic s_stop;
  logic s_rise;
  logic s_fall;
  i2cbl_mem_wr_t push_data;

  function automatic logic [7:0] tx_byte(input logic [2:0] s, input logic [15:0] a);
    case (s)
      STP_AW: tx_byte = {EE_DEV, 1'b0}; // RL12
      STP_SH: tx_byte = a[15:8];
      STP_SL: tx_byte = a[7:0];
      default: tx_byte = {EE_DEV, 1'b1}; // RL5
    endcase
  endfunction

  // ****************************************************************
  // Loader decisions on each completed byte.
  // ****************************************************************
  assign tick = (st_r != S_SLAVE) && (cnt_r == QTR_LAST) && fifo_in_ready; // RL26
  assign rd = step_r == STP_RD;
  assign bdone = tick && (st_r == S_BYTE) && (q_r == 2'h3) && (bit_r == BIT_ACK);
  assign ee_pos = {1'b0, base_r} + {1'b0, pos_r}; // RL14
  assign hdr_end = pos_r == POS_HDR_LAST;
  assign id_bad = hdr_end && ((id_r != HDR_ID) || // RL24
    ((tot_r != '0) && (tot_r < HDR_LEN + CKS_LEN)));
  assign term = hdr_end && !id_bad && (tot_r == '0); // RL23
  assign is_data = (pos_r >= HDR_LEN) && (pos_r < tot_r - CKS_LEN);
  assign blk_end = (pos_r >= HDR_LEN) && (pos_r == tot_r - 16'h0001);
  assign cks_ok = (cks_hdr_r == {cke_hi_r, sh_r}) && (cks_hdr_r == sum_r); // RL20
  assign eom = (ee_pos + 17'h00001) >= 17'(EE_BYTES);
  assign fault = bdone && (rd ? (id_bad || (blk_end && !cks_ok) || (eom && !term)) // RL15
    : sda_i);
  // The byte that ends the read is left unacknowledged so the memory frees the line for the stop.
  assign rd_stop = rd && (id_bad || term || (blk_end && !cks_ok) || eom); // RL15 RL27
  assign mem_push = bdone && rd && is_data && !fault &&
    !((sel_r == MEM_MCU_PROG) && mcu_locked); // RL10 RL18 RL25
  assign push_data = '{sel: sel_r, addr: start_r + (pos_r - HDR_LEN), data: sh_r};

  // Bus-rate quarter counter; it halts while the FIFO is full.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
    end
    else if (st_r == S_SLAVE || tick)
    begin
      cnt_r <= '0;
    end
    else if (fifo_in_ready)
    begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  // ****************************************************************
  // Master sequencing: start, byte, stop and retries.
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= S_START;
      q_r <= '0;
      bit_r <= '0;
      step_r <= STP_AW;
      sh_r <= '0;
      m_scl_low_r <= 1'b0;
      m_sda_low_r <= 1'b0;
      fin_r <= 1'b0;
      fail_r <= 1'b0;
      tries_r <= '0;
      pos_r <= '0;
      base_r <= '0;
      mcu_locked <= 1'b0;
      mem_rd_err <= 1'b0;
      boot_done <= 1'b0;
      boot_err <= 1'b0;
      use_default <= 1'b0;
    end
    else if (tick)
    begin
      q_r <= q_r + 2'h1;
      case (st_r)
        S_START:
        begin
          case (q_r)
            2'h0: m_sda_low_r <= 1'b0;
            2'h1: m_scl_low_r <= 1'b0;
            2'h2: m_sda_low_r <= 1'b1; // RL3
            default:
            begin
              m_scl_low_r <= 1'b1;
              st_r <= S_BYTE;
              bit_r <= '0;
              sh_r <= tx_byte(step_r, ee_pos[15:0]);
            end
          endcase
        end
        S_BYTE:
        begin
          case (q_r)
            2'h1: m_sda_low_r <= (bit_r == BIT_ACK) ? (rd && !rd_stop) : // RL13 RL27
              (!rd && !sh_r[7]); // RL1 RL4
            2'h2: m_scl_low_r <= 1'b0;
            2'h3:
            begin
              m_scl_low_r <= 1'b1;
              if (bit_r != BIT_ACK)
              begin
                sh_r <= {sh_r[6:0], rd ? sda_i : 1'b0}; // RL1
                bit_r <= bit_r + 4'h1;
              end
              else if (fault)
              begin
                st_r <= S_STOP;
                pos_r <= '0;
                if (rd && blk_end && !cks_ok)
                begin
                  mem_rd_err <= 1'b1; // RL20
                end
                if (tries_r == TRIES_LAST)
                begin
                  fail_r <= 1'b1; // RL16 RL17
                end
                else
                begin
                  tries_r <= tries_r + 2'h1;
                end
              end
              else if (!rd)
              begin
                bit_r <= '0;
                if (step_r == STP_SL)
                begin
                  st_r <= S_START; // RL11
                  step_r <= STP_AR;
                end
                else
                begin
                  step_r <= step_r + 3'h1; // RL12
                  sh_r <= tx_byte(step_r + 3'h1, ee_pos[15:0]);
                end
              end
              else if (term)
              begin
                st_r <= S_STOP;
                fin_r <= 1'b1; // RL23
              end
              else
              begin
                bit_r <= '0;
                if (blk_end)
                begin
                  base_r <= base_r + tot_r; // RL14
                  pos_r <= '0;
                  tries_r <= '0;
                  if (sel_r == MEM_MCU_PROG)
                  begin
                    mcu_locked <= 1'b1; // RL18
                  end
                end
                else
                begin
                  pos_r <= pos_r + 16'h0001;
                end
              end
            end
            default:
            begin
            end
          endcase
        end
        S_STOP:
        begin
          case (q_r)
            2'h0: m_sda_low_r <= 1'b1;
            2'h1: m_scl_low_r <= 1'b0;
            2'h2: m_sda_low_r <= 1'b0; // RL3 RL27
            default:
            begin
              if (fin_r || fail_r)
              begin
                st_r <= S_SLAVE; // RL19
                boot_done <= fin_r;
                boot_err <= fail_r;
                use_default <= fail_r;
              end
              else
              begin
                st_r <= S_START;
                step_r <= STP_AW;
              end
            end
          endcase
        end
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Header capture and running checksum.
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cks_hdr_r <= '0;
      id_r <= '0;
      sel_r <= '0;
      start_r <= '0;
      tot_r <= '0;
      cke_hi_r <= '0;
      sum_r <= '0;
    end
    else if (bdone && rd)
    begin
      case (pos_r)
        POS_CKS_HI: cks_hdr_r[15:8] <= sh_r;
        POS_CKS_LO: cks_hdr_r[7:0] <= sh_r;
        POS_ID_HI: id_r[15:8] <= sh_r;
        POS_ID_LO: id_r[7:0] <= sh_r;
        POS_SEL: sel_r <= sh_r;
        POS_ADR_HI: start_r[15:8] <= sh_r;
        POS_ADR_LO: start_r[7:0] <= sh_r;
        POS_TOT_HI: tot_r[15:8] <= sh_r;
        POS_TOT_LO: tot_r[7:0] <= sh_r;
        default:
        begin
          if (pos_r == tot_r - CKS_LEN)
          begin
            cke_hi_r <= sh_r;
          end
        end
      endcase
      if (pos_r == POS_CKS_HI)
      begin
        sum_r <= '0;
      end
      else if (pos_r >= POS_ID_HI && (pos_r < HDR_LEN || pos_r < tot_r - CKS_LEN))
      begin
        sum_r <= sum_r + {8'h00, sh_r}; // RL21
      end
    end
  end

  i2cbl_fifo #(
    .W($bits(i2cbl_mem_wr_t)),
    .D(4)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(mem_push),
    .in_data(push_data),
    .in_ready(fifo_in_ready),
    .out_valid(mem_wr_valid),
    .out_data(mem_wr_data),
    .out_ready(mem_wr_ready)
  );

  // ****************************************************************
  // Subaddress slave, active once the boot download is over.
  // ****************************************************************
  assign s_start = scl_q_r && scl_i && sda_q_r && !sda_i;
  assign s_stop = scl_q_r && scl_i && !sda_q_r && sda_i;
  assign s_rise = !scl_q_r && scl_i;
  assign s_fall = scl_q_r && !scl_i;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sl_st_r <= SL_IDLE;
      s_sda_low_r <= 1'b0;
      sl_sh_r <= '0;
      sl_bit_r <= '0;
      sl_first_r <= 1'b0;
      sl_rd_r <= 1'b0;
      sl_sub_pend_r <= 1'b0;
      slv_wr <= 1'b0;
      slv_wdata <= '0;
      slv_sub <= '0;
    end
    else
    begin
      slv_wr <= 1'b0;
      if (st_r != S_SLAVE)
      begin
        sl_st_r <= SL_IDLE;
        s_sda_low_r <= 1'b0;
      end
      else if (s_start)
      begin
        sl_st_r <= SL_RX;
        sl_bit_r <= '0;
        sl_first_r <= 1'b1;
        s_sda_low_r <= 1'b0;
      end
      else if (s_stop)
      begin
        sl_st_r <= SL_IDLE;
        s_sda_low_r <= 1'b0;
      end
      else
      begin
        case (sl_st_r)
          SL_RX:
          begin
            if (s_rise)
            begin
              sl_sh_r <= {sl_sh_r[6:0], sda_i}; // RL1
              sl_bit_r <= sl_bit_r + 4'h1;
            end
            else if (s_fall && sl_bit_r == BIT_ACK)
            begin
              sl_bit_r <= '0;
              if (sl_first_r)
              begin
                sl_first_r <= 1'b0;
                if (sl_sh_r[7:1] == SLV_ADDR)
                begin
                  sl_st_r <= SL_ACK;
                  s_sda_low_r <= 1'b1; // RL2
                  sl_rd_r <= sl_sh_r[0];
                  sl_sub_pend_r <= !sl_sh_r[0]; // RL9
                end
                else
                begin
                  sl_st_r <= SL_IDLE;
                end
              end
              else
              begin
                sl_st_r <= SL_ACK; // RL6
                s_sda_low_r <= 1'b1;
                if (sl_sub_pend_r)
                begin
                  slv_sub <= sl_sh_r; // RL8
                  sl_sub_pend_r <= 1'b0;
                end
                else
                begin
                  slv_wr <= 1'b1;
                  slv_wdata <= '{addr: slv_sub, data: sl_sh_r};
                  slv_sub <= slv_sub + 8'h01;
                end
              end
            end
          end
          SL_ACK, SL_MACK:
          begin
            if (s_rise && sl_st_r == SL_MACK && sda_i)
            begin
              sl_st_r <= SL_IDLE;
            end
            else if (s_fall && sl_rd_r)
            begin
              sl_st_r <= SL_TX;
              sl_sh_r <= slv_rdata;
              s_sda_low_r <= !slv_rdata[7];
              slv_sub <= slv_sub + 8'h01;
            end
            else if (s_fall)
            begin
              sl_st_r <= SL_RX;
              s_sda_low_r <= 1'b0;
            end
          end
          SL_TX:
          begin
            if (s_fall && sl_bit_r == BIT_LAST)
            begin
              sl_st_r <= SL_MACK;
              s_sda_low_r <= 1'b0;
              sl_bit_r <= '0;
            end
            else if (s_fall)
            begin
              sl_sh_r <= {sl_sh_r[6:0], 1'b0};
              s_sda_low_r <= !sl_sh_r[6];
              sl_bit_r <= sl_bit_r + 4'h1;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Pin drivers; the enable is low while a line is pulled down.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n <= !((st_r != S_SLAVE) && m_scl_low_r);
      sda_oe_n <= !((st_r == S_SLAVE) ? s_sda_low_r : m_sda_low_r);
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_sda_low_clk: assert property ( // RL4
    (st_r == S_BYTE && $changed(m_sda_low_r)) |-> m_scl_low_r)
    else $error("data line moved while clock high");
  chk_start_edge: assert property ( // RL3
    (st_r == S_START && $rose(m_sda_low_r)) |-> !m_scl_low_r)
    else $error("start not made with clock high");
  chk_stop_end: assert property ( // RL27
    $rose(st_r == S_SLAVE) |-> $past(st_r) == S_STOP && !m_sda_low_r && !m_scl_low_r)
    else $error("master left without a stop");
  chk_ack_read: assert property ( // RL13
    (st_r == S_BYTE && rd && !rd_stop && bit_r == BIT_ACK && !m_scl_low_r) |-> m_sda_low_r)
    else $error("read byte not acknowledged");
  chk_last_nack: assert property ( // RL27
    (st_r == S_BYTE && rd_stop && bit_r == BIT_ACK && !m_scl_low_r) |-> !m_sda_low_r)
    else $error("last read byte acknowledged");
  chk_dir_write: assert property ( // RL12
    (st_r == S_BYTE && step_r == STP_AW && bit_r == 4'h0) |-> sh_r == {EE_DEV, 1'b0})
    else $error("first address byte not a write");
  chk_rstart_seq: assert property ( // RL11
    $rose(step_r == STP_AR) |-> st_r == S_START && $past(st_r) == S_BYTE)
    else $error("read not entered by repeated start");
  chk_mcu_lock: assert property ( // RL18
    (mem_push && sel_r == MEM_MCU_PROG) |-> !mcu_locked)
    else $error("controller program reloaded");
  chk_retry_cap: assert property ( // RL16
    $rose(boot_err) |-> tries_r == TRIES_LAST && use_default && !boot_done)
    else $error("error declared at wrong attempt");
  chk_fail_quiet: assert property ( // RL19
    boot_err |=> scl_oe_n && st_r == S_SLAVE)
    else $error("master active after error");
  chk_slave_ack: assert property ( // RL2
    (sl_st_r == SL_ACK && scl_q_r && scl_i) |-> s_sda_low_r)
    else $error("slave ack not held low");
endmodule
`default_nettype wire

/* File: testbench/i2cbl_ee_model.sv */
// Serial memory model answering the loader's sequential reads.
`timescale 1ns/1ns
`default_nettype none
module i2cbl_ee_model (
  // Bus wires.
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  int bn = 0;
  int st = 3;
  int ptr = 0;
  logic mute = 1'b0;
  initial pull = 1'b0;
  always @(negedge sda)
    if (scl)
    begin
      st = 0;
      bn = -1;
      pull = 1'b0;
    end
  always @(posedge sda)
    if (scl)
      st = 3;
  always @(posedge scl)
    if (st == 2 && bn == 8 && sda)
      st = 3;
    else if (st == 0 || st == 1)
      sh = {sh[6:0], sda};
  always @(negedge scl)
    if (st != 3)
    begin
      if (bn == 8)
      begin
        bn = 0;
        pull = 1'b0;
        if (st == 2)
          sh = mem[ptr];
        if (st == 2)
          ptr = (ptr + 1) % 256;
      end
      else if (bn == 7 && st == 2)
      begin
        bn = 8;
        pull = 1'b0;
      end
      else if (bn == 7)
      begin
        bn = 8;
        if (st == 1)
          ptr = 32'(sh);
        else
          st = (sh[7:1] == 7'h50 && !mute) ? 1 + int'(sh[0]) : 3;
        pull = (st != 3);
      end
      else
        bn = bn + 1;
      if (st == 2 && bn < 8)
        pull = ~sh[7 - bn];
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Bench for the boot loader and subaddress slave with a serial memory model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import i2cbl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mem_wr_ready = 1'b0;
  logic hs_scl = 1'b0;
  logic hs_sda = 1'b0;
  logic ee_pull, scl_o, scl_oe_n, sda_o, sda_oe_n, mem_wr_valid, slv_wr;
  logic boot_done, boot_err, use_default, mem_rd_err, mcu_locked;
  logic [7:0] slv_sub;
  i2cbl_mem_wr_t mem_wr_data;
  i2cbl_slv_wr_t slv_wdata;
  wire logic scl_w = scl_oe_n & ~hs_scl;
  wire logic sda_w = sda_oe_n & ~ee_pull & ~hs_sda;
  wire logic [7:0] slv_rdata = slv_sub ^ 8'hC3;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int starts = 0;
  int stops = 0;
  int wrs = 0;
  logic [31:0] exp_q [$];
  logic [7:0] img [0:29];
  logic [8:0] r;
  logic [15:0] adr;
  logic [15:0] sum;
  logic [7:0] d;
  i2cbl_top #(.EE_BYTES(256)) u_i2cbl_top (.clk(clk), .rst(rst), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
    .slv_wr(slv_wr), .slv_wdata(slv_wdata), .slv_sub(slv_sub), .slv_rdata(slv_rdata),
    .boot_done(boot_done), .boot_err(boot_err), .use_default(use_default),
    .mem_rd_err(mem_rd_err), .mcu_locked(mcu_locked));
  i2cbl_ee_model u_i2cbl_ee_model (.scl(scl_w), .sda(sda_w), .pull(ee_pull));
  initial forever #5 clk = ~clk;
  always @(negedge clk) mem_wr_ready <= 1'($urandom);
  always @(negedge sda_w) if (scl_w && !boot_done && !rst) starts++;
  always @(posedge sda_w) if (scl_w && !boot_done && !rst) stops++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (slv_wr)
      wrs++;
    if (mem_wr_valid && mem_wr_ready)
      check(mem_wr_data, exp_q.size() ? exp_q.pop_front() : 32'hX);
    if (cyc == 99000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic hq;
    repeat (10) @(negedge clk);
  endtask
  task automatic h_start;
    hs_sda = 1'b1;
    hq();
    hs_scl = 1'b1;
    hq();
  endtask
  task automatic h_stop;
    hs_sda = 1'b1;
    hq();
    hs_scl = 1'b0;
    hq();
    hs_sda = 1'b0;
    hq();
  endtask
  // The low bit of b is the host's own ack slot: 1 releases the line.
  task automatic h_byte(input logic [8:0] b, output logic [8:0] q);
    for (int j = 0; j < 9; j++)
    begin
      hs_sda = ~b[8 - j];
      hq();
      hs_scl = 1'b0;
      hq();
      q = {q[7:0], sda_w};
      hs_scl = 1'b1;
      hq();
    end
  endtask
  task automatic wr(input logic [7:0] b [$], input logic nak);
    h_start();
    foreach (b[k])
    begin
      h_byte({b[k], 1'b1}, r);
      check(r[0], (k == 0) ? nak : 1'b0);
    end
    h_stop();
  endtask
  initial
  begin
    void'($urandom(85));
    img = '{default: 8'h00};
    adr = 16'($urandom);
    sum = 16'h0031 + 16'(adr[15:8]) + 16'(adr[7:0]);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      img[12 + i] = d;
      sum = sum + 16'(d);
      exp_q.push_back({MEM_MCU_PROG, adr + 16'(i), d});
    end
    {img[0], img[1]} = sum;
    {img[16], img[17]} = sum;
    {img[6], img[7]} = adr;
    img[3] = 8'h1F;
    img[9] = 8'h12;
    img[21] = 8'h1F;
    for (int i = 0; i < 256; i++)
      u_i2cbl_ee_model.mem[i] = (i < 30) ? img[i] : 8'h00;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    wait (boot_done || boot_err);
    repeat (20) @(negedge clk);
    check(boot_done, 1);
    check({boot_err, use_default, mem_rd_err}, 0);
    check(mcu_locked, 1);
    check(exp_q.size(), 0);
    check(starts, 2);
    check(stops, 1);
    check({scl_o, sda_o}, 0);
    $display("boot download test done");
    wr('{8'h6A}, 1'b1);
    wr('{8'h68, 8'h10, 8'hA5}, 1'b0);
    check(slv_wdata, 16'h10A5);
    wr('{8'h68, 8'h20}, 1'b0);
    wr('{8'h68, 8'h30, 8'h5A, 8'h5B}, 1'b0);
    check(slv_wdata, 16'h315B);
    check(wrs, 3);
    wr('{8'h68, 8'h40}, 1'b0);
    h_start();
    h_byte(9'h0D3, r);
    check(r[0], 0);
    h_byte(9'h1FF, r);
    check(r[8:1], 8'h83);
    h_stop();
    $display("slave access test done");
    u_i2cbl_ee_model.mute = 1'b1;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    check(mcu_locked, 0);
    rst = 1'b0;
    wait (boot_done || boot_err);
    repeat (20) @(negedge clk);
    check({boot_done, boot_err, use_default, scl_oe_n}, 4'h7);
    check(starts, 5);
    check(stops, 4);
    $display("missing memory test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
